// File: src/serial_ports.sv
// Two independent asynchronous serial ports with software flow control.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
module serial_ports
	import serial_pkg::*;
#(
	parameter int CYC_110 = BIT_CYC_110,
	parameter int CYC_300 = BIT_CYC_300,
	parameter int CYC_1200 = BIT_CYC_1200,
	parameter int CYC_2400 = BIT_CYC_2400,
	parameter int CYC_4800 = BIT_CYC_4800,
	parameter int CYC_9600 = BIT_CYC_9600,
	parameter int CYC_19200 = BIT_CYC_19200
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire bus_req_t bus_req,
	output logic [DATA_W-1:0] rd_data,
	input wire logic [NUM_PORTS-1:0] rxd,
	output logic [NUM_PORTS-1:0] txd
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		port_cfg_t cfg;
		tx_state_t tx_st;
		logic [CNT_W-1:0] tx_cnt;
		logic [3:0] tx_left;
		logic [11:0] tx_shift;
		logic txd;
		rx_state_t rx_st;
		logic [CNT_W-1:0] rx_cnt;
		logic [3:0] rx_idx;
		logic [11:0] rx_shift;
		logic [2:0] rx_sync;
		logic rx_line;
		logic [DATA_W-1:0] rx_data;
		logic rx_valid;
		logic par_err;
		logic frm_err;
		logic overrun;
		logic paused;
	} chan_t;

	typedef struct packed {
		chan_t [NUM_PORTS-1:0] ch;
		logic [DATA_W-1:0] rd_data;
	} state_t;

	function automatic state_t reset_state();
		state_t s;
		s = '0;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			s.ch[p].cfg = CFG_RESET;
			s.ch[p].txd = LINE_MARK;
			s.ch[p].rx_line = LINE_MARK;
			s.ch[p].rx_sync = {3{LINE_MARK}};
		end
		return s;
	endfunction

	localparam state_t STATE_RST = reset_state();

	function automatic logic [CNT_W-1:0] bit_cycles(input logic [2:0] rate);
		logic [CNT_W-1:0] n;
		n = CNT_W'(CYC_19200);
		case (rate)
			RATE_110: n = CNT_W'(CYC_110);
			RATE_300: n = CNT_W'(CYC_300);
			RATE_1200: n = CNT_W'(CYC_1200);
			RATE_2400: n = CNT_W'(CYC_2400);
			RATE_4800: n = CNT_W'(CYC_4800);
			RATE_9600: n = CNT_W'(CYC_9600);
			default: n = CNT_W'(CYC_19200);
		endcase
		return n;
	endfunction

	// The parity bit that makes the count of ones odd or even over the data bits.
	function automatic logic parity_bit(input logic [7:0] data, input port_cfg_t cfg);
		logic [7:0] m;
		m = data;
		if (cfg.data7)
		begin
			m[7] = 1'b0;
		end
		return (^m) ^ (cfg.parity == PAR_ODD);
	endfunction

	state_t q;
	state_t d;
	logic [NUM_PORTS-1:0] buf_in_valid;
	logic [NUM_PORTS-1:0] buf_in_ready;
	logic [NUM_PORTS-1:0] buf_out_valid;
	logic [NUM_PORTS-1:0] tx_take;
	logic [NUM_PORTS-1:0][DATA_W-1:0] buf_out_data;

	assign rd_data = q.rd_data;

	////////////////////////////////////////////////////////////////////////////////
	// Per-port transmit buffer

	for (genvar g = 0; g < NUM_PORTS; g++)
	begin : g_port
		assign buf_in_valid[g] = bus_req.wr && (bus_req.addr[7:4] == 4'(g))
			&& (bus_req.addr[3:0] == REG_TXD);
		// A new character may only start from idle and not while paused.
		assign tx_take[g] = (q.ch[g].tx_st == TX_IDLE)
			&& !(q.ch[g].cfg.flow_en && q.ch[g].paused); // see R8 see R9 see R10
		assign txd[g] = q.ch[g].txd;

		serial_txbuf #(
			.WIDTH(DATA_W),
			.DEPTH(TXBUF_DEPTH)
		) u_txbuf (
			.clk(clk),
			.rst_n(rst_n),
			.in_valid(buf_in_valid[g]),
			.in_ready(buf_in_ready[g]),
			.in_data(bus_req.wdata),
			.out_valid(buf_out_valid[g]),
			.out_ready(tx_take[g]),
			.out_data(buf_out_data[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		logic hit;
		logic [3:0] off;
		logic [CNT_W-1:0] cyc;
		logic [3:0] dw;
		logic has_par;
		logic [3:0] nbits;
		logic [11:0] frame;
		logic [11:0] rxs;
		logic [7:0] rx_byte;
		logic bit_in;
		hit = 1'b0;
		off = '0;
		cyc = '0;
		dw = '0;
		has_par = 1'b0;
		nbits = '0;
		frame = '0;
		rxs = '0;
		rx_byte = '0;
		bit_in = 1'b0;
		d = q;
		d.rd_data = '0;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			hit = (bus_req.addr[7:4] == 4'(p));
			off = bus_req.addr[3:0];
			cyc = bit_cycles(q.ch[p].cfg.rate); // see R2
			dw = q.ch[p].cfg.data7 ? 4'h7 : 4'h8; // see R6
			has_par = (q.ch[p].cfg.parity != PAR_NONE); // see R5

			// Software side; clears come first so that a hardware set in the
			// same cycle overrides them.
			if (bus_req.wr && hit && off == REG_CFG)
			begin
				d.ch[p].cfg = port_cfg_t'(bus_req.wdata); // see R1 see R12
			end
			if (bus_req.rd && hit)
			begin
				case (off)
					REG_CFG: d.rd_data = q.ch[p].cfg; // see R13
					REG_RXD:
					begin
						d.rd_data = q.ch[p].rx_data;
						d.ch[p].rx_valid = 1'b0;
					end
					REG_STAT:
					begin
						d.rd_data[STAT_TX_SPACE] = buf_in_ready[p];
						d.rd_data[STAT_RX_VALID] = q.ch[p].rx_valid;
						d.rd_data[STAT_PAUSED] = q.ch[p].paused;
						d.rd_data[STAT_TX_BUSY] = (q.ch[p].tx_st == TX_SEND);
						d.rd_data[STAT_PAR_ERR] = q.ch[p].par_err;
						d.rd_data[STAT_FRM_ERR] = q.ch[p].frm_err;
						d.rd_data[STAT_OVERRUN] = q.ch[p].overrun;
						d.ch[p].par_err = 1'b0;
						d.ch[p].frm_err = 1'b0;
						d.ch[p].overrun = 1'b0;
					end
					default: d.rd_data = '0;
				endcase
			end

			// Transmitter.
			unique case (q.ch[p].tx_st)
				TX_IDLE:
				begin
					d.ch[p].txd = LINE_MARK; // see R14
					if (tx_take[p] && buf_out_valid[p])
					begin
						frame = '1;
						frame[0] = 1'b0; // see R3
						for (int i = 0; i < 8; i++)
						begin
							if (4'(i) < dw)
							begin
								frame[1 + i] = buf_out_data[p][i]; // see R14
							end
						end
						if (has_par)
						begin
							frame[1 + dw] = parity_bit(buf_out_data[p], q.ch[p].cfg); // see R5
						end
						nbits = 4'h2 + dw + {3'h0, has_par} + {3'h0, q.ch[p].cfg.stop2}; // see R4
						d.ch[p].txd = frame[0];
						d.ch[p].tx_shift = {1'b1, frame[11:1]};
						d.ch[p].tx_left = nbits - 4'h1;
						d.ch[p].tx_cnt = cyc - 1'b1;
						d.ch[p].tx_st = TX_SEND;
					end
				end
				TX_SEND:
				begin
					if (q.ch[p].tx_cnt != '0)
					begin
						d.ch[p].tx_cnt = q.ch[p].tx_cnt - 1'b1;
					end
					else if (q.ch[p].tx_left == '0)
					begin
						d.ch[p].tx_st = TX_IDLE;
					end
					else
					begin
						d.ch[p].txd = q.ch[p].tx_shift[0];
						d.ch[p].tx_shift = {1'b1, q.ch[p].tx_shift[11:1]};
						d.ch[p].tx_left = q.ch[p].tx_left - 1'b1;
						d.ch[p].tx_cnt = cyc - 1'b1;
					end
				end
			endcase

			// Receive pin: a level is taken once the second and third stages agree.
			d.ch[p].rx_sync = {q.ch[p].rx_sync[1:0], rxd[p]};
			if (q.ch[p].rx_sync[1] == q.ch[p].rx_sync[2])
			begin
				d.ch[p].rx_line = q.ch[p].rx_sync[2];
			end

			// Receiver samples mid-bit; only the first stop bit is checked.
			unique case (q.ch[p].rx_st)
				RX_IDLE:
				begin
					if (q.ch[p].rx_line != LINE_MARK)
					begin
						d.ch[p].rx_st = RX_RECV;
						d.ch[p].rx_cnt = cyc >> 1;
						d.ch[p].rx_idx = '0;
					end
				end
				RX_RECV:
				begin
					bit_in = q.ch[p].rx_line;
					rxs = q.ch[p].rx_shift;
					rxs[q.ch[p].rx_idx] = bit_in;
					if (q.ch[p].rx_cnt != '0)
					begin
						d.ch[p].rx_cnt = q.ch[p].rx_cnt - 1'b1;
					end
					else if (q.ch[p].rx_idx == '0 && bit_in == LINE_MARK)
					begin
						d.ch[p].rx_st = RX_IDLE; // see R3
					end
					else if (q.ch[p].rx_idx != 4'h1 + dw + {3'h0, has_par})
					begin
						d.ch[p].rx_shift = rxs;
						d.ch[p].rx_idx = q.ch[p].rx_idx + 1'b1;
						d.ch[p].rx_cnt = cyc - 1'b1;
					end
					else
					begin
						d.ch[p].rx_st = RX_IDLE;
						rx_byte = rxs[8:1]; // see R14
						if (q.ch[p].cfg.data7)
						begin
							rx_byte[7] = 1'b0; // see R6
						end
						if (!bit_in)
						begin
							d.ch[p].frm_err = 1'b1; // see R4
						end
						if (has_par && rxs[1 + dw] != parity_bit(rx_byte, q.ch[p].cfg))
						begin
							d.ch[p].par_err = 1'b1; // see R5
						end
						// Flow bytes are consumed while flow control is on, so
						// they never reach the receive register.
						if (q.ch[p].cfg.flow_en && rx_byte == XOFF_CHAR)
						begin
							d.ch[p].paused = 1'b1; // see R8 see R10
						end
						else if (q.ch[p].cfg.flow_en && rx_byte == XON_CHAR)
						begin
							d.ch[p].paused = 1'b0; // see R9
						end
						else
						begin
							if (d.ch[p].rx_valid)
							begin
								d.ch[p].overrun = 1'b1;
							end
							d.ch[p].rx_data = rx_byte;
							d.ch[p].rx_valid = 1'b1;
						end
					end
				end
			endcase

			// With flow control off a stale pause must not hold the transmitter.
			if (!d.ch[p].cfg.flow_en)
			begin
				d.ch[p].paused = 1'b0; // see R7
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= STATE_RST;
		end
		else
		begin
			q <= d;
		end
	end

endmodule

// File: inc/serial_pkg.sv
// Shared constants and types for the two-port asynchronous serial block.
//
// Function
// R1: Each of the two ports has its own framing, rate and flow-control settings.
// R2: The bit rate is one of 110, 300, 1200, 2400, 4800, 9600 or 19200 bit/s.
// R3: Every frame starts with exactly one start bit.
// R4: A frame ends with one or two stop bits, as selected.
// R5: Parity is odd, even or absent, placed after the data bits.
// R6: A character carries 7 or 8 data bits, as selected.
// R7: Flow-control bytes gate transmission only while flow control is enabled.
// R8: With flow control on, a received 13 hex byte stops new characters from starting.
// R9: While paused, a received 11 hex byte lets queued characters go out again.
// R10: A pause byte that completes after a character has started lets that character finish.
// R11: The far end uses the same rate, stop, parity, width and flow settings as the port.
// R12: A port setting stays in force until reset or until a new setting is written.
// R13: The applied settings of each port can be read back.
// R14: The line idles at mark, data go LSB first and parity sits before the first stop bit.
package serial_pkg;

	localparam int CLK_HZ = 10_000_000;
	localparam int NUM_PORTS = 2;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 17;
	localparam int TXBUF_DEPTH = 2;

	localparam int BAUD_110 = 110;
	localparam int BAUD_300 = 300;
	localparam int BAUD_1200 = 1200;
	localparam int BAUD_2400 = 2400;
	localparam int BAUD_4800 = 4800;
	localparam int BAUD_9600 = 9600;
	localparam int BAUD_19200 = 19200;

	// A bit time is a longest time, so the division rounds down.
	localparam int BIT_CYC_110 = CLK_HZ / BAUD_110;
	localparam int BIT_CYC_300 = CLK_HZ / BAUD_300;
	localparam int BIT_CYC_1200 = CLK_HZ / BAUD_1200;
	localparam int BIT_CYC_2400 = CLK_HZ / BAUD_2400;
	localparam int BIT_CYC_4800 = CLK_HZ / BAUD_4800;
	localparam int BIT_CYC_9600 = CLK_HZ / BAUD_9600;
	localparam int BIT_CYC_19200 = CLK_HZ / BAUD_19200;

	localparam logic [2:0] RATE_110 = 3'h0;
	localparam logic [2:0] RATE_300 = 3'h1;
	localparam logic [2:0] RATE_1200 = 3'h2;
	localparam logic [2:0] RATE_2400 = 3'h3;
	localparam logic [2:0] RATE_4800 = 3'h4;
	localparam logic [2:0] RATE_9600 = 3'h5;
	localparam logic [2:0] RATE_19200 = 3'h6;

	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ODD = 2'h1;
	localparam logic [1:0] PAR_EVEN = 2'h2;

	localparam logic [7:0] XOFF_CHAR = 8'h13;
	localparam logic [7:0] XON_CHAR = 8'h11;
	localparam logic LINE_MARK = 1'b1;

	// Register map: address bits [7:4] pick the port, bits [3:0] the register.
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_TXD = 4'h4;
	localparam logic [3:0] REG_RXD = 4'h8;
	localparam logic [3:0] REG_STAT = 4'hc;

	localparam int STAT_TX_SPACE = 0;
	localparam int STAT_RX_VALID = 1;
	localparam int STAT_PAUSED = 2;
	localparam int STAT_TX_BUSY = 3;
	localparam int STAT_PAR_ERR = 4;
	localparam int STAT_FRM_ERR = 5;
	localparam int STAT_OVERRUN = 6;

	typedef struct packed {
		logic flow_en;
		logic data7;
		logic [1:0] parity;
		logic stop2;
		logic [2:0] rate;
	} port_cfg_t;

	localparam port_cfg_t CFG_RESET = '{flow_en: 1'b0, data7: 1'b0, parity: PAR_NONE,
		stop2: 1'b0, rate: RATE_19200};

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

	typedef enum logic [0:0] {TX_IDLE, TX_SEND} tx_state_t;
	typedef enum logic [0:0] {RX_IDLE, RX_RECV} rx_state_t;

endpackage

// File: src/serial_txbuf.sv
// Small valid/ready buffer that holds characters waiting for the transmitter.
`timescale 1ns/1ps
module serial_txbuf
	import serial_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = TXBUF_DEPTH
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [PW:0] count;
	} buf_state_t;

	buf_state_t q;
	buf_state_t d;
	logic push;
	logic pop;

	assign in_ready = (q.count != FULL);
	assign out_valid = (q.count != '0);
	assign out_data = q.mem[q.rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		d = q;
		if (push)
		begin
			d.mem[q.wr_ptr] = in_data;
			d.wr_ptr = (q.wr_ptr == LAST) ? '0 : q.wr_ptr + 1'b1;
		end
		if (pop)
		begin
			d.rd_ptr = (q.rd_ptr == LAST) ? '0 : q.rd_ptr + 1'b1;
		end
		if (push && !pop)
		begin
			d.count = q.count + 1'b1;
		end
		else if (pop && !push)
		begin
			d.count = q.count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

endmodule

// File: test/serial_ports_sva.sv
// Port-level assertions for the two-port serial block.
`timescale 1ns/1ps
module serial_ports_sva
	import serial_pkg::*;
#(
	parameter int MAX_BIT = BIT_CYC_110
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire bus_req_t bus_req,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic [NUM_PORTS-1:0] rxd,
	input wire logic [NUM_PORTS-1:0] txd
);
	// Start, eight data bits and parity make the longest low run a frame can hold.
	localparam int LOW_MAX = 10 * MAX_BIT;
	int low_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			low_q <= 0;
		else
			low_q <= txd[0] ? 0 : low_q + 1;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////
	a_read_quiet: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
		else $error("read data outside answer cycle");
	a_cfg_readback: assert property ((bus_req.wr && bus_req.addr[3:0] == REG_CFG
		&& bus_req.addr[7:4] < 4'h2 ##1 bus_req.rd && bus_req.addr == $past(bus_req.addr))
		|=> rd_data == $past(bus_req.wdata, 2)) else $error("config not read back");
	a_unmapped_zero: assert property (bus_req.rd && bus_req.addr[7:4] > 4'h1
		|=> rd_data == 8'h00) else $error("unmapped read not zero");
	a_stat_top: assert property (bus_req.rd && bus_req.addr[3:0] == REG_STAT
		|=> !rd_data[7]) else $error("status top bit set");
	a_idle_reset: assert property ($rose(rst_n) |-> txd == 2'h3 [*2])
		else $error("line not at mark after reset");
	a_start0_len: assert property ($fell(txd[0]) |-> !txd[0] [*8])
		else $error("short low bit on port 0");
	a_mark0_len: assert property ($rose(txd[0]) |-> txd[0] [*8])
		else $error("short high bit on port 0");
	a_start1_len: assert property ($fell(txd[1]) |-> !txd[1] [*8])
		else $error("short low bit on port 1");
	a_mark1_len: assert property ($rose(txd[1]) |-> txd[1] [*8])
		else $error("short high bit on port 1");
	a_low_run: assert property (low_q <= LOW_MAX)
		else $error("line low longer than a frame allows");
endmodule
bind serial_ports serial_ports_sva #(.MAX_BIT(CYC_110)) serial_ports_sva_inst (.clk(clk),
	.rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data), .rxd(rxd), .txd(txd));

// File: test/serial_peer.sv
// Behavioural far-end serial device that receives and sends frames.
`timescale 1ns/1ps
module serial_peer
	import serial_pkg::*;
(
	input wire logic clk,
	input wire logic line_in,
	input wire port_cfg_t cfg,
	input wire logic [7:0] bit_cyc,
	output logic line_out
);
	logic [8:0] rxq[$];
	longint t_start[$];
	logic [7:0] b;
	logic ok;
	initial line_out = LINE_MARK;
	task automatic hold(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic bit_out(input logic v);
		line_out <= v;
		hold(bit_cyc);
	endtask
	// Sampling at mid-bit with its own bit time makes a wrong rate show as bad data.
	always
	begin
		@(negedge line_in);
		t_start.push_back($time);
		hold(bit_cyc / 2);
		ok = !line_in;
		b = 8'h00;
		for (int i = 0; i < (cfg.data7 ? 7 : 8); i++)
		begin
			hold(bit_cyc);
			b[i] = line_in;
		end
		if (cfg.parity != PAR_NONE)
		begin
			hold(bit_cyc);
			ok &= (^b ^ line_in) == (cfg.parity == PAR_ODD);
		end
		repeat (cfg.stop2 ? 2 : 1)
		begin
			hold(bit_cyc);
			ok &= line_in;
		end
		rxq.push_back({ok, b});
	end
	task automatic send(input logic [7:0] d);
		bit_out(1'b0);
		for (int i = 0; i < (cfg.data7 ? 7 : 8); i++)
			bit_out(d[i]);
		if (cfg.parity != PAR_NONE)
			bit_out(^(d & (cfg.data7 ? 8'h7f : 8'hff)) ^ (cfg.parity == PAR_ODD));
		repeat (cfg.stop2 ? 2 : 1)
			bit_out(LINE_MARK);
	endtask
endmodule

// File: test/serial_port_flow_control_uart_tb_top.sv
// Self-checking bench for the two-port serial block.
`timescale 1ns/1ps
module serial_port_flow_control_uart_tb_top
	import serial_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	bus_req_t bus_req = '0;
	logic [7:0] rd_data;
	wire [1:0] rxd;
	logic [1:0] txd;
	port_cfg_t cfg0 = CFG_RESET;
	port_cfg_t cfg1 = CFG_RESET;
	logic [7:0] bit1 = 8'h10;
	int checked = 0;
	int n_mismatch = 0;
	logic [8:0] v;
	always #50 clk = ~clk;
	serial_ports #(.CYC_110(28), .CYC_300(26), .CYC_1200(24), .CYC_2400(22), .CYC_4800(20),
		.CYC_9600(18), .CYC_19200(16)) serial_ports_inst (.clk(clk), .rst_n(rst_n),
		.bus_req(bus_req), .rd_data(rd_data), .rxd(rxd), .txd(txd));
	serial_peer peer0 (.clk(clk), .line_in(txd[0]), .cfg(cfg0), .bit_cyc(bit1),
		.line_out(rxd[0]));
	serial_peer peer1 (.clk(clk), .line_in(txd[1]), .cfg(cfg1), .bit_cyc(bit1),
		.line_out(rxd[1]));
	////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		bus_req <= '0;
		@(posedge clk);
		v = {1'b0, rd_data};
	endtask
	task automatic idle(input int n);
		bus_req <= '0;
		repeat (n) @(posedge clk);
	endtask
	// Waits until the chosen peer holds n characters, giving up after a bounded time.
	task automatic wait_rx(input bit p, input int n);
		int k = 0;
		bus_req <= '0;
		while ((p ? peer1.rxq.size() : peer0.rxq.size()) < n && k < 5000)
		begin
			@(posedge clk);
			k++;
		end
		if (k == 5000)
		begin
			n_mismatch++;
			final_report();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(8'h00);
		chk(v, {1'b0, CFG_RESET});
		rd(8'h10);
		chk(v, {1'b0, CFG_RESET});
		rd(8'h0c);
		chk(v, 9'h001);
		rd(8'h2c);
		chk(v, 9'h000);
	endtask
	task automatic t_rates();
		for (int r = 0; r < 7; r++)
		begin
			wr(8'h10, {5'h00, 3'(r)});
			bit1 <= 8'h1c - 8'(2 * r);
			wr(8'h14, 8'h50 + 8'(r));
			wait_rx(1'b1, r + 1);
			chk(peer1.rxq[r], {1'b1, 8'h50 + 8'(r)});
		end
	endtask
	task automatic t_formats();
		port_cfg_t fm [4] = '{8'h6e, 8'h16, 8'h46, 8'h2e};
		logic [7:0] m;
		int n;
		for (int i = 0; i < 4; i++)
		begin
			peer0.rxq.delete();
			peer0.t_start.delete();
			m = fm[i].data7 ? 8'h7f : 8'hff;
			n = 1 + (fm[i].data7 ? 7 : 8) + (fm[i].parity != PAR_NONE) + (fm[i].stop2 ? 2 : 1);
			wr(8'h00, fm[i]);
			cfg0 <= fm[i];
			rd(8'h00);
			chk(v, {1'b0, fm[i]});
			wr(8'h04, 8'ha5);
			wr(8'h04, 8'hc3);
			wait_rx(1'b0, 2);
			chk(peer0.rxq[0], {1'b1, 8'ha5 & m});
			chk(peer0.rxq[1], {1'b1, 8'hc3 & m});
			chk(9'((peer0.t_start[1] - peer0.t_start[0]) / 100), 9'(n * 16 + 1));
			peer0.send(8'hb7);
			idle(4);
			rd(8'h08);
			chk(v, {1'b0, 8'hb7 & m});
		end
	endtask
	task automatic t_flow();
		wr(8'h00, 8'h86);
		cfg0 <= 8'h86;
		idle(1);
		peer0.rxq.delete();
		peer0.send(XOFF_CHAR);
		idle(4);
		rd(8'h0c);
		chk(v, 9'h005);
		wr(8'h04, 8'h31);
		wr(8'h04, 8'h32);
		wr(8'h04, 8'h33);
		rd(8'h0c);
		chk(v, 9'h004);
		idle(400);
		chk(9'(peer0.rxq.size()), 9'h000);
		peer0.send(XON_CHAR);
		wait_rx(1'b0, 2);
		idle(400);
		chk(9'(peer0.rxq.size()), 9'h002);
		chk(peer0.rxq[1], 9'h132);
		// The pause byte ends while 41h is on the line, so only 42h is held back.
		peer0.rxq.delete();
		wr(8'h04, 8'h41);
		wr(8'h04, 8'h42);
		// A write leaves its strobe up, so it is dropped before the long send.
		bus_req <= '0;
		peer0.send(XOFF_CHAR);
		idle(400);
		chk(9'(peer0.rxq.size()), 9'h001);
		wr(8'h00, 8'h06);
		cfg0 <= 8'h06;
		wait_rx(1'b0, 2);
		chk(peer0.rxq[1], 9'h142);
		peer0.send(XOFF_CHAR);
		idle(4);
		rd(8'h08);
		chk(v, 9'h013);
	endtask
	// The far end sends with the wrong parity, then a break, to raise every error flag.
	task automatic t_errors();
		wr(8'h10, 8'h16);
		cfg1 <= 8'h26;
		idle(1);
		peer1.send(8'h5a);
		peer1.send(8'h5a);
		idle(4);
		rd(8'h1c);
		chk(v, 9'h053);
		rd(8'h1c);
		chk(v, 9'h003);
		rd(8'h18);
		chk(v, 9'h05a);
		repeat (11) peer1.bit_out(1'b0);
		peer1.bit_out(1'b1);
		idle(4);
		rd(8'h1c);
		chk(v, 9'h033);
		rd(8'h18);
		chk(v, 9'h000);
		cfg1 <= 8'h16;
		wr(8'h14, 8'h77);
		rd(8'h1c);
		rd(8'h1c);
		chk(v, 9'h009);
		wait_rx(1'b1, 8);
		chk(peer1.rxq[7], 9'h177);
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_rates();
		t_formats();
		t_flow();
		t_errors();
		final_report();
	end
endmodule
